// File: design/hbi_dev.sv
`timescale 1ns/10ps
`default_nettype none
`include "hbi_cfg.svh"
// Summary of operation
// - ALE level or toggling picks bus type
// - Any ALE edge switches to multiplexed bus
// - Multiplexed mode left only by reset
// - Eight-bit data bus for all programming
// - Multiplexed addresses even, AD0 zero
// - Demux decode: four address lines plus bank
// - Bank one init regs, zero operational
// - Mode register visible in both banks
// - Interrupt pin flags pending, status shows cause
// - Interrupt level, held while sources pending
// - Interrupt dropped during mask write access
// - Host rewrites mask after service routine
// - Masked source hidden from status and pin
// - Host writes slot pointer into control memory
// - Signalling change: interrupt, FIFO push, store
// - Sync transfer window interrupts, two channels
// - Seven-bit periodic hardware timer
// - Four address lines beside eight data
// - Reset held five clocks, registers reset
// - ALE sampled during reset for bus type
module hbi_dev
  import hbi_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  hbi_if.dev bus,
  input wire logic sig_chg,
  input wire logic [6:0] sig_chan,
  input wire logic [7:0] sig_val,
  output var hbi_mode_t mode_q,
  output logic bank_q
);
  logic strap_q;
  logic ale_q;
  logic mux_q;
  logic [7:0] alat_q;
  logic rd_act;
  logic wr_act;
  logic [3:0] idx;
  logic idx_ok;
  logic rd_q;
  logic wr_q;
  logic [4:0] sel_q;
  logic [7:0] wd_q;
  logic wr_done;
  logic rd_done;
  logic [7:0] dout_q;
  logic doe_q;
  logic int_q;
  logic [`HBI_NI-1:0] interrupt_status_register_q;
  logic [`HBI_NI-1:0] mask_q;
  logic [`HBI_NI-1:0] ev;
  logic [`HBI_NI-1:0] clr;
  logic [6:0] cmad_q;
  logic [7:0] cm_q [`HBI_CM_N];
  logic [6:0] fifo_q [`HBI_FIFO_D];
  logic [3:0] wp_q;
  logic [3:0] rp_q;
  logic [3:0] cnt_q;
  logic push;
  logic pop;
  logic [6:0] tper_q;
  logic [6:0] tcnt_q;
  logic [7:0] sya_q;
  logic [7:0] syb_q;
  logic [6:0] slot_q;

  function automatic logic is_reg(input logic [4:0] s, input logic [3:0] a, input logic b);
    is_reg = (s[3:0] == a) && (s[4] == b || a == `HBI_A_OPERATION_MODE_REGISTER);
  endfunction

  function automatic logic [3:0] inc9(input logic [3:0] p);
    inc9 = (p == `HBI_FIFO_D - 4'h1) ? 4'h0 : p + 4'h1;
  endfunction

  // ****************
  // Bus type selection
  // ****************
  // Strap flop has no async reset so it may follow the pin while reset holds
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      strap_q <= bus.ale;
    end
  end

  always_ff @(posedge ref_clk) begin
    ale_q <= bus.ale;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mux_q <= 1'b0;
    end else if (ale_q != bus.ale) begin
      mux_q <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= HBI_INTEL;
    end else begin
      mode_q <= (mux_q || ale_q != bus.ale) ? HBI_MUX : (strap_q ? HBI_MOTO : HBI_INTEL);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      alat_q <= 8'h00;
    end else if (ale_q && !bus.ale) begin
      alat_q <= bus.dq;
    end
  end

  // ****************
  // Access decode
  // ****************
  always_comb begin
    if (mode_q == HBI_MOTO) begin
      rd_act = !bus.cs_n && !bus.rd_n && bus.wr_n;
      wr_act = !bus.cs_n && !bus.rd_n && !bus.wr_n;
    end else begin
      rd_act = !bus.cs_n && !bus.rd_n;
      wr_act = !bus.cs_n && !bus.wr_n;
    end
    idx = (mode_q == HBI_MUX) ? alat_q[4:1] : bus.addr;
    idx_ok = (mode_q != HBI_MUX) || !alat_q[0];
  end

  // Writes commit when the strobe ends, so data settled late in the access is used
  assign wr_done = wr_q && !wr_act;
  assign rd_done = rd_q && !rd_act;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      sel_q <= 5'h00;
      wd_q <= 8'h00;
    end else begin
      rd_q <= rd_act && idx_ok;
      wr_q <= wr_act && idx_ok;
      if ((rd_act || wr_act) && idx_ok) begin
        sel_q <= {bank_q, idx};
        wd_q <= bus.dq;
      end
    end
  end

  // ****************
  // Register writes
  // ****************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bank_q <= 1'b0;
      mask_q <= '0;
      cmad_q <= 7'h00;
      tper_q <= 7'h00;
      sya_q <= 8'h00;
      syb_q <= 8'h00;
    end else if (wr_done) begin
      if (is_reg(sel_q, `HBI_A_OPERATION_MODE_REGISTER, 1'b0)) begin
        bank_q <= wd_q[0];
      end
      if (is_reg(sel_q, `HBI_A_MASK, 1'b0)) begin
        mask_q <= wd_q[`HBI_NI-1:0];
      end
      if (is_reg(sel_q, `HBI_A_CMAD, 1'b0)) begin
        cmad_q <= wd_q[6:0];
      end
      if (is_reg(sel_q, `HBI_A_TMR, 1'b1)) begin
        tper_q <= wd_q[6:0];
      end
      if (is_reg(sel_q, `HBI_A_SYA, 1'b1)) begin
        sya_q <= wd_q;
      end
      if (is_reg(sel_q, `HBI_A_SYB, 1'b1)) begin
        syb_q <= wd_q;
      end
    end
  end

  // Control memory is not cleared by reset
  always_ff @(posedge ref_clk) begin
    if (sig_chg) begin
      cm_q[sig_chan] <= sig_val;
    end
    if (wr_done && is_reg(sel_q, `HBI_A_CMDT, 1'b0)) begin
      cm_q[cmad_q] <= wd_q;
    end
  end

  // ****************
  // Channel FIFO
  // ****************
  assign push = sig_chg && cnt_q != `HBI_FIFO_D;
  assign pop = rd_done && is_reg(sel_q, `HBI_A_CIF, 1'b0) && cnt_q != 4'h0;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q <= 4'h0;
      rp_q <= 4'h0;
      cnt_q <= 4'h0;
    end else begin
      if (push) begin
        wp_q <= inc9(wp_q);
      end
      if (pop) begin
        rp_q <= inc9(rp_q);
      end
      cnt_q <= cnt_q + {3'h0, push} - {3'h0, pop};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) begin
      fifo_q[wp_q] <= sig_chan;
    end
  end

  // ****************
  // Timer and sync windows
  // ****************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tcnt_q <= 7'h00;
      slot_q <= 7'h00;
    end else begin
      slot_q <= slot_q + 7'h01;
      tcnt_q <= (tcnt_q == 7'h00) ? tper_q : tcnt_q - 7'h01;
    end
  end

  // ****************
  // Interrupts
  // ****************
  always_comb begin
    ev = '0;
    ev[`HBI_I_SIG] = push;
    ev[`HBI_I_OVF] = sig_chg && !push;
    ev[`HBI_I_SYA] = sya_q[7] && slot_q == sya_q[6:0];
    ev[`HBI_I_SYB] = syb_q[7] && slot_q == syb_q[6:0];
    ev[`HBI_I_TMR] = tper_q != 7'h00 && tcnt_q == 7'h00;
    clr = (wr_done && is_reg(sel_q, `HBI_A_INTERRUPT_STATUS_REGISTER, 1'b0)) ? wd_q[`HBI_NI-1:0] : '0;
  end

  // Status is write-one-to-clear; a new event in the same cycle wins
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      interrupt_status_register_q <= '0;
    end else begin
      interrupt_status_register_q <= (interrupt_status_register_q & ~clr & ~mask_q) | (ev & ~mask_q);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      int_q <= 1'b0;
    end else begin
      int_q <= (|interrupt_status_register_q) && !(wr_act && idx == `HBI_A_MASK && !bank_q);
    end
  end

  // ****************
  // Read data
  // ****************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dout_q <= 8'h00;
      doe_q <= 1'b0;
    end else begin
      doe_q <= rd_act && idx_ok;
      case ({bank_q, idx})
        {1'b0, `HBI_A_OPERATION_MODE_REGISTER}, {1'b1, `HBI_A_OPERATION_MODE_REGISTER}: dout_q <= {7'h00, bank_q};
        {1'b0, `HBI_A_INTERRUPT_STATUS_REGISTER}: dout_q <= {3'h0, interrupt_status_register_q};
        {1'b0, `HBI_A_MASK}: dout_q <= {3'h0, mask_q};
        {1'b0, `HBI_A_CMAD}: dout_q <= {1'b0, cmad_q};
        {1'b0, `HBI_A_CMDT}: dout_q <= cm_q[cmad_q];
        {1'b0, `HBI_A_CIF}: dout_q <= {1'b0, fifo_q[rp_q]};
        {1'b1, `HBI_A_TMR}: dout_q <= {1'b0, tper_q};
        {1'b1, `HBI_A_SYA}: dout_q <= sya_q;
        {1'b1, `HBI_A_SYB}: dout_q <= syb_q;
        default: dout_q <= 8'h00;
      endcase
    end
  end

  assign bus.dq_d = dout_q;
  assign bus.dq_d_oe = doe_q;
  assign bus.int_o = int_q;
endmodule
`default_nettype wire

// File: design/hbi_cfg.svh
`ifndef HBI_CFG_SVH
`define HBI_CFG_SVH
// ****************
// Device register indices (bank select prefixed)
// ****************
`define HBI_A_OPERATION_MODE_REGISTER 4'hf
`define HBI_A_INTERRUPT_STATUS_REGISTER 4'h0
`define HBI_A_MASK 4'h1
`define HBI_A_CMAD 4'h2
`define HBI_A_CMDT 4'h3
`define HBI_A_CIF 4'h4
`define HBI_A_TMR 4'h0
`define HBI_A_SYA 4'h1
`define HBI_A_SYB 4'h2
// ****************
// Interrupt status bits
// ****************
`define HBI_I_SIG 0
`define HBI_I_SYA 1
`define HBI_I_SYB 2
`define HBI_I_TMR 3
`define HBI_I_OVF 4
`define HBI_NI 5
// ****************
// Sizes and timing
// ****************
`define HBI_FIFO_D 4'h9
`define HBI_CM_N 128
`define HBI_RES_NS 16
`define HBI_RES_CYC (((`HBI_RES_NS) + 3) / 4)
`define HBI_STRB_CYC 3'h4
// ****************
// Host command port byte offsets
// ****************
`define HBI_H_CTRL 4'h0
`define HBI_H_STAT 4'h4
`define HBI_H_CONF 4'h8
`endif

// File: design/hbi_pkg.sv
`default_nettype none
package hbi_pkg;
  typedef enum logic [1:0] {HBI_MOTO, HBI_INTEL, HBI_MUX} hbi_mode_t;
  typedef enum {HS_IDLE, HS_ALE_H, HS_ALE_L, HS_STRB, HS_END, HS_RES} hbi_hst_t;
endpackage
`default_nettype wire

// File: design/hbi_if.sv
`timescale 1ns/10ps
`default_nettype none
interface hbi_if;
  logic ale;
  logic cs_n;
  logic rd_n;
  logic wr_n;
  logic [3:0] addr;
  logic [7:0] dq_h;
  logic dq_h_oe;
  logic [7:0] dq_d;
  logic dq_d_oe;
  logic int_o;
  logic res_n;
  logic [7:0] dq;
  // Bus keeper view: device drive wins, then host, else all ones
  assign dq = dq_d_oe ? dq_d : (dq_h_oe ? dq_h : 8'hff);
  modport dev(input ale, cs_n, rd_n, wr_n, addr, dq, output dq_d, dq_d_oe, int_o);
  modport host(output ale, cs_n, rd_n, wr_n, addr, dq_h, dq_h_oe, res_n, input dq, int_o);
endinterface
`default_nettype wire

// File: design/hbi_host.sv
`timescale 1ns/10ps
`default_nettype none
`include "hbi_cfg.svh"
module hbi_host
  import hbi_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  hbi_if.host bus,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  hbi_hst_t st_q;
  hbi_mode_t conf_q;
  logic aw_q, w_q, go_q, rd_cmd_q, busy_q, ale_q, cs_n_q, rd_n_q, wr_n_q, oe_q, res_n_q;
  logic [3:0] awa_q;
  logic [3:0] ra_q;
  logic [31:0] wd_q;
  logic [7:0] cwd_q;
  logic [7:0] rdat_q;
  logic [7:0] dq_q;
  logic [2:0] cnt_q;
  logic do_wr;

  // ****************
  // Command registers on AXI4-Lite
  // ****************
  assign do_wr = aw_q && w_q && !s_axi_bvalid;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awa_q <= 4'h0;
      wd_q <= 32'h0;
      go_q <= 1'b0;
      rd_cmd_q <= 1'b0;
      ra_q <= 4'h0;
      cwd_q <= 8'h00;
      conf_q <= HBI_INTEL;
    end else begin
      go_q <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awa_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wd_q <= s_axi_wdata;
        s_axi_wready <= 1'b0;
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awa_q == `HBI_H_CTRL || awa_q == `HBI_H_CONF) ? 2'h0 : 2'h2;
        // Commands arriving while busy are dropped
        if (awa_q == `HBI_H_CTRL && !busy_q) begin
          go_q <= wd_q[0] | wd_q[2];
          rd_cmd_q <= wd_q[1];
          ra_q <= wd_q[11:8];
          cwd_q <= wd_q[23:16];
        end
        if (awa_q == `HBI_H_CONF && wd_q[1:0] != 2'h3) begin
          conf_q <= hbi_mode_t'(wd_q[1:0]);
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      case (s_axi_araddr)
        `HBI_H_CTRL: s_axi_rdata <= {8'h00, cwd_q, 4'h0, ra_q, 6'h00, rd_cmd_q, 1'b0};
        `HBI_H_STAT: s_axi_rdata <= {15'h0, bus.int_o, rdat_q, 7'h00, busy_q};
        `HBI_H_CONF: s_axi_rdata <= {30'h0, conf_q};
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ****************
  // Pin sequencer
  // ****************
  // Device reset runs once after own reset; ALE shows the chosen strap meanwhile
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= HS_RES;
      busy_q <= 1'b1;
      cnt_q <= 3'h0;
      res_n_q <= 1'b0;
      ale_q <= 1'b0;
      cs_n_q <= 1'b1;
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
      oe_q <= 1'b0;
      dq_q <= 8'h00;
      rdat_q <= 8'h00;
    end else begin
      case (st_q)
        HS_IDLE: begin
          busy_q <= go_q;
          cnt_q <= 3'h0;
          if (go_q && wd_q[2]) begin
            st_q <= HS_RES;
            res_n_q <= 1'b0;
          end else if (go_q) begin
            st_q <= (conf_q == HBI_MUX) ? HS_ALE_H : HS_STRB;
            ale_q <= (conf_q == HBI_MUX) ? 1'b1 : ale_q;
            oe_q <= (conf_q == HBI_MUX);
            dq_q <= {3'h0, ra_q, 1'b0};
            cs_n_q <= (conf_q == HBI_MUX);
            // Motorola data strobe is low for both directions; Intel read strobe only for reads
            rd_n_q <= (conf_q == HBI_MUX) || (conf_q == HBI_INTEL && !rd_cmd_q);
            wr_n_q <= (conf_q == HBI_MOTO) ? rd_cmd_q : !(conf_q == HBI_INTEL && !rd_cmd_q);
          end
        end
        HS_ALE_H: begin
          st_q <= HS_ALE_L;
          ale_q <= 1'b0;
        end
        HS_ALE_L: begin
          st_q <= HS_STRB;
          cs_n_q <= 1'b0;
          rd_n_q <= !rd_cmd_q;
          wr_n_q <= rd_cmd_q;
          oe_q <= !rd_cmd_q;
          dq_q <= cwd_q;
        end
        HS_STRB: begin
          cnt_q <= cnt_q + 3'h1;
          oe_q <= !rd_cmd_q;
          dq_q <= cwd_q;
          if (cnt_q == `HBI_STRB_CYC - 3'h1) begin
            st_q <= HS_END;
            rdat_q <= rd_cmd_q ? bus.dq : rdat_q;
            cs_n_q <= 1'b1;
            rd_n_q <= 1'b1;
            wr_n_q <= (conf_q != HBI_MOTO);
          end
        end
        HS_END: begin
          st_q <= HS_IDLE;
          oe_q <= 1'b0;
          wr_n_q <= 1'b1;
          busy_q <= 1'b0;
        end
        HS_RES: begin
          ale_q <= (conf_q == HBI_MOTO);
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == 3'(`HBI_RES_CYC)) begin
            res_n_q <= 1'b1;
            st_q <= HS_END;
          end
        end
        default: st_q <= HS_IDLE;
      endcase
    end
  end

  assign bus.ale = ale_q;
  assign bus.cs_n = cs_n_q;
  assign bus.rd_n = rd_n_q;
  assign bus.wr_n = wr_n_q;
  assign bus.addr = ra_q;
  assign bus.dq_h = dq_q;
  assign bus.dq_h_oe = oe_q;
  assign bus.res_n = res_n_q;
endmodule
`default_nettype wire

// File: testbench/hbi_assertions.sv
`timescale 1ns/10ps
`default_nettype none
`include "hbi_cfg.svh"
module hbi_assertions
  import hbi_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ale,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [3:0] addr,
  input wire logic dq_d_oe,
  input wire logic int_o,
  input wire hbi_mode_t mode_q,
  input wire logic bank_q
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ********
  // Bus type selection
  // ********
  property p_mux_enter;
    $changed(ale) |=> mode_q == HBI_MUX;
  endproperty
  a_mux_enter: assert property (p_mux_enter) else $error("ale edge did not select multiplexed bus");
  property p_mux_stay;
    mode_q == HBI_MUX |=> mode_q == HBI_MUX;
  endproperty
  a_mux_stay: assert property (p_mux_stay) else $error("left multiplexed bus without reset");
  property p_strap;
    $rose(rst_n) |=> mode_q == ($past(ale) ? HBI_MOTO : HBI_INTEL);
  endproperty
  a_strap: assert property (p_strap) else $error("bus type not taken from ale strap");
  // ********
  // Strobes and data drive
  // ********
  property p_cs_gate;
    cs_n |=> !dq_d_oe;
  endproperty
  a_cs_gate: assert property (p_cs_gate) else $error("device drove data without chip select");
  property p_intel_rd;
    mode_q == HBI_INTEL && !cs_n && !rd_n |=> dq_d_oe;
  endproperty
  a_intel_rd: assert property (p_intel_rd) else $error("read strobe got no data drive");
  property p_moto_wr;
    mode_q == HBI_MOTO && !cs_n && !wr_n |=> !dq_d_oe;
  endproperty
  a_moto_wr: assert property (p_moto_wr) else $error("device drove data during write cycle");
  // ********
  // Interrupt pin
  // ********
  property p_int_mask_wr;
    mode_q == HBI_INTEL && !bank_q && !cs_n && !wr_n && addr == `HBI_A_MASK |=> !int_o;
  endproperty
  a_int_mask_wr: assert property (p_int_mask_wr) else $error("interrupt high during mask write");
  // Only a host access may retire a pending source
  property p_int_hold;
    $fell(int_o) |-> !$past(cs_n) || !$past(cs_n, 2) || !$past(cs_n, 3) || !$past(cs_n, 4);
  endproperty
  a_int_hold: assert property (p_int_hold) else $error("interrupt dropped without host access");
  c_int_rise: cover property ($rose(int_o));
  c_mux: cover property (mode_q == HBI_MUX && !cs_n);
  c_moto_rd: cover property (mode_q == HBI_MOTO && !cs_n && !rd_n && wr_n);
endmodule
`default_nettype wire

// File: testbench/host_bus_interrupt_port_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "hbi_cfg.svh"
module host_bus_interrupt_port_tb
  import hbi_pkg::*;
;
  typedef struct {logic [31:0] v; logic [31:0] m; logic [1:0] r;} hbi_exp_t;
  logic ref_clk;
  logic rst_n;
  logic dev_rst_n;
  logic sig_chg;
  logic [6:0] sig_chan;
  logic [7:0] sig_val;
  hbi_mode_t mode_q;
  logic bank_q;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, rng_q, rd_q;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int errors;
  int checked;
  hbi_exp_t exp_q[$];
  hbi_if i_hbi_if();
  assign dev_rst_n = rst_n & i_hbi_if.res_n;
  hbi_dev i_hbi_dev(.ref_clk, .rst_n(dev_rst_n), .bus(i_hbi_if), .sig_chg, .sig_chan, .sig_val, .mode_q, .bank_q);
  hbi_host i_hbi_host(.ref_clk, .rst_n, .bus(i_hbi_if), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  hbi_assertions i_hbi_assertions(.ref_clk, .rst_n(dev_rst_n), .ale(i_hbi_if.ale), .cs_n(i_hbi_if.cs_n),
    .rd_n(i_hbi_if.rd_n), .wr_n(i_hbi_if.wr_n), .addr(i_hbi_if.addr), .dq_d_oe(i_hbi_if.dq_d_oe),
    .int_o(i_hbi_if.int_o), .mode_q, .bank_q);
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // ********
  // Checking
  // ********
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cmp(input logic [1:0] r, input logic [31:0] d);
    hbi_exp_t e;
    e = exp_q.pop_front();
    check({r, d & e.m}, {e.r, e.v});
  endtask
  always @(posedge ref_clk) begin
    if (s_axi_bvalid && s_axi_bready) cmp(s_axi_bresp, 32'h0);
    if (s_axi_rvalid && s_axi_rready) cmp(s_axi_rresp, s_axi_rdata);
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction
  // ********
  // Bus tasks
  // ********
  // Ready lines stay high throughout, so every answer is taken on the edge it appears
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw;
    logic w;
    exp_q.push_back('{32'h0, 32'h0, r});
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge ref_clk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge ref_clk); while (!s_axi_bvalid);
  endtask
  task automatic axi_rd(input logic [3:0] a, input logic [31:0] v, input logic [31:0] m, input logic [1:0] r);
    exp_q.push_back('{v, m, r});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge ref_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge ref_clk); while (!s_axi_rvalid);
    rd_q = s_axi_rdata;
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    repeat (2) @(posedge ref_clk);
    rd_q = 32'h1;
    while (rd_q[0] && n < 50) begin
      axi_rd(`HBI_H_STAT, 32'h0, 32'h0, 2'b00);
      n++;
    end
    if (rd_q[0]) errors++;
  endtask
  task automatic dev_op(input logic rd, input logic [3:0] idx, input logic [7:0] d);
    axi_wr(`HBI_H_CTRL, {8'h00, d, 4'h0, idx, 6'h00, rd, 1'b1}, 2'b00);
    wait_idle();
  endtask
  task automatic dev_rd(input logic [3:0] idx, input logic [7:0] v);
    dev_op(1'b1, idx, 8'h00);
    axi_rd(`HBI_H_STAT, {16'h0, v, 8'h0}, 32'h0000ff00, 2'b00);
  endtask
  task automatic int_pin(input logic v);
    axi_rd(`HBI_H_STAT, {15'h0, v, 16'h0}, 32'h00010000, 2'b00);
  endtask
  task automatic dev_reset(input logic [31:0] conf);
    axi_wr(`HBI_H_CONF, conf, 2'b00);
    axi_wr(`HBI_H_CTRL, 32'h4, 2'b00);
    wait_idle();
  endtask
  task automatic sig_pulse();
    rng_q = xs(rng_q);
    sig_chan <= rng_q[6:0];
    sig_val <= rng_q[15:8];
    sig_chg <= 1'b1;
    @(posedge ref_clk);
    sig_chg <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    report_and_stop();
  end
  // ********
  // Scenarios
  // ********
  initial begin
    rst_n = 1'b0;
    sig_chg = 1'b0;
    sig_chan = 7'h00;
    sig_val = 8'h00;
    s_axi_awaddr = 4'h0;
    s_axi_araddr = 4'h0;
    s_axi_wstrb = 4'hf;
    s_axi_wdata = 32'h0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    rng_q = 32'h3b98;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    wait_idle();
    check({32'h0, mode_q}, {32'h0, HBI_INTEL});
    axi_wr(4'hc, 32'h0, 2'b10);
    axi_rd(4'hc, 32'h0, 32'h0, 2'b10);
    axi_rd(`HBI_H_CONF, 32'h1, 32'h3, 2'b00);
    dev_op(1'b0, `HBI_A_MASK, 8'h1e);
    dev_op(1'b0, `HBI_A_OPERATION_MODE_REGISTER, 8'h01);
    dev_rd(`HBI_A_OPERATION_MODE_REGISTER, 8'h01);
    dev_op(1'b0, `HBI_A_SYA, 8'h85);
    dev_rd(`HBI_A_SYA, 8'h85);
    dev_op(1'b0, `HBI_A_TMR, 8'h7f);
    dev_op(1'b0, `HBI_A_OPERATION_MODE_REGISTER, 8'h00);
    dev_rd(`HBI_A_MASK, 8'h1e);
    dev_rd(`HBI_A_INTERRUPT_STATUS_REGISTER, 8'h00);
    int_pin(1'b0);
    rng_q = xs(rng_q);
    dev_op(1'b0, `HBI_A_CMAD, rng_q[7:0] & 8'h7f);
    dev_op(1'b0, `HBI_A_CMDT, rng_q[15:8]);
    dev_op(1'b0, `HBI_A_CMAD, rng_q[7:0] & 8'h7f);
    dev_rd(`HBI_A_CMDT, rng_q[15:8]);
    sig_pulse();
    int_pin(1'b1);
    dev_rd(`HBI_A_INTERRUPT_STATUS_REGISTER, 8'h01);
    dev_rd(`HBI_A_CIF, {1'b0, rng_q[6:0]});
    dev_op(1'b0, `HBI_A_CMAD, {1'b0, rng_q[6:0]});
    dev_rd(`HBI_A_CMDT, rng_q[15:8]);
    dev_op(1'b0, `HBI_A_MASK, 8'h1c);
    repeat (130) @(posedge ref_clk);
    dev_rd(`HBI_A_INTERRUPT_STATUS_REGISTER, 8'h03);
    dev_op(1'b0, `HBI_A_INTERRUPT_STATUS_REGISTER, 8'h01);
    int_pin(1'b1);
    dev_op(1'b0, `HBI_A_MASK, 8'h17);
    repeat (300) @(posedge ref_clk);
    dev_rd(`HBI_A_INTERRUPT_STATUS_REGISTER, 8'h08);
    dev_op(1'b0, `HBI_A_MASK, 8'h1f);
    dev_rd(`HBI_A_INTERRUPT_STATUS_REGISTER, 8'h00);
    int_pin(1'b0);
    dev_op(1'b0, `HBI_A_OPERATION_MODE_REGISTER, 8'h01);
    dev_reset(32'h2);
    dev_rd(`HBI_A_OPERATION_MODE_REGISTER, 8'h00);
    dev_rd(`HBI_A_MASK, 8'h00);
    dev_op(1'b0, `HBI_A_MASK, 8'h1a);
    dev_rd(`HBI_A_MASK, 8'h1a);
    check({32'h0, mode_q}, {32'h0, HBI_MUX});
    dev_reset(32'h0);
    check({32'h0, mode_q}, {32'h0, HBI_MOTO});
    dev_op(1'b0, `HBI_A_OPERATION_MODE_REGISTER, 8'h01);
    dev_rd(`HBI_A_OPERATION_MODE_REGISTER, 8'h01);
    dev_reset(32'h1);
    check({32'h0, mode_q}, {32'h0, HBI_INTEL});
    // Bus type code 3 is not a valid strap choice and must leave the setting alone
    axi_wr(`HBI_H_CONF, 32'h3, 2'b00);
    axi_rd(`HBI_H_CONF, 32'h1, 32'h3, 2'b00);
    report_and_stop();
  end
endmodule
`default_nettype wire
